/* File: bench/axi_host.sv */
`timescale 1ns/100ps
`default_nettype none
module axi_host (
   input  wire logic        clock_i,
   output var  logic [7:0]  awaddr_o,
   output var  logic        awvalid_o,
   input  wire logic        awready_i,
   output var  logic [31:0] wdata_o,
   output var  logic        wvalid_o,
   input  wire logic        wready_i,
   input  wire logic [1:0]  bresp_i,
   input  wire logic        bvalid_i,
   output var  logic        bready_o,
   output var  logic [7:0]  araddr_o,
   output var  logic        arvalid_o,
   input  wire logic        arready_i,
   input  wire logic [31:0] rdata_i,
   input  wire logic [1:0]  rresp_i,
   input  wire logic        rvalid_i,
   output var  logic        rready_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Idle bus at time zero
   initial begin
      {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
      {araddr_o, arvalid_o, rready_o} = '0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rsp);
      int n;
      rsp = 2'h3;
      @(posedge clock_i);
      awaddr_o <= a;
      wdata_o <= dat;
      awvalid_o <= 1'h1;
      wvalid_o <= 1'h1;
      bready_o <= 1'h1;
      for (n = 0; n < 64; n++) begin
         @(posedge clock_i);
         if (awready_i && awvalid_o) awvalid_o <= 1'h0;
         if (wready_i && wvalid_o) wvalid_o <= 1'h0;
         if (bvalid_i) begin
            bready_o <= 1'h0;
            rsp = bresp_i;
            break;
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // One read
   task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
      int n;
      rsp = 2'h3;
      dat = 'x;
      @(posedge clock_i);
      araddr_o <= a;
      arvalid_o <= 1'h1;
      rready_o <= 1'h1;
      for (n = 0; n < 64; n++) begin
         @(posedge clock_i);
         if (arready_i && arvalid_o) arvalid_o <= 1'h0;
         if (rvalid_i) begin
            rready_o <= 1'h0;
            dat = rdata_i;
            rsp = rresp_i;
            break;
         end
      end
   endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb import alu_pkg::*;;
   typedef struct {logic [31:0] c, a, b, s; logic [3:0] fi; logic [31:0] d; logic [3:0] fe;} row_s;
   localparam logic [31:0] av = 32'hF0F0_1234;
   localparam logic [31:0] bv = 32'h0FF0_00FF;
   localparam logic [31:0] d0 = 32'h5A5A_5A5A;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, branch_addr, br_addr, d;
   logic [1:0]  bresp, rresp, r;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, branch;
   logic        arvalid, arready, rvalid, rready, resetn_i;
   logic        clock_i = 1'h0;
   int          n_errors = 0, checked = 0, n_br = 0, i;
   row_s        t [22];
   ////////////////////////////////////////////////////////////////////////////
   always #5 clock_i = ~clock_i;
   logic_shift_move_alu dut (.clock_i(clock_i), .resetn_i(resetn_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .branch_o(branch),
      .branch_addr_o(branch_addr));
   axi_host host (.clock_i(clock_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
      .awready_i(awready), .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready),
      .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
      .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
      .rvalid_i(rvalid), .rready_o(rready));
   always @(posedge clock_i) begin
      if (branch === 1'h1) begin
         n_br <= n_br + 1;
         br_addr <= branch_addr;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] cw(input logic [3:0] op, input logic [2:0] sk,
                                      input logic [5:0] amt, input logic imm, input logic s);
      return {1'h1, 12'h000, 1'h0, 1'h1, s, 2'h0, amt, imm, sk, op};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #100000;
      n_errors++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////////////////////
   // Operand rows; no stack or program counter operand
   initial begin
      t[0] = '{cw(op_conj, shift_none, 6'h00, 1'h0, 1'h1), av, bv, 0, 4'h3, 32'h00F0_0034, 4'h3};
      t[1] = '{cw(bitwise_xor_op, shift_none, 6'h00, 1'h0, 1'h0), av, bv, 0, 4'h5, 32'hFF00_12CB, 4'h5};
      t[2] = '{cw(bitwise_disjunction, shift_none, 6'h00, 1'h0, 1'h1), av, bv, 0, 4'h0, 32'hFFF0_12FF, 4'h8};
      t[3] = '{cw(bit_clear_op, shift_none, 6'h00, 1'h0, 1'h1), av, bv, 0, 4'h1, 32'hF000_1200, 4'h9};
      t[4] = '{cw(disjunction_inverted, shift_none, 6'h00, 1'h0, 1'h0), av, bv, 0, 4'hF, 32'hF0FF_FF34, 4'hF};
      t[5] = '{cw(leading_zero_count, shift_none, 6'h00, 1'h0, 1'h1), av, bv, 0, 4'hA, 32'h4, 4'hA};
      t[6] = '{cw(leading_zero_count, shift_none, 6'h00, 1'h0, 1'h0), av, 0, 0, 4'h0, 32'h20, 4'h0};
      t[7] = '{cw(leading_zero_count, shift_none, 6'h00, 1'h0, 1'h0), av, 32'h8000_0000, 0, 4'h0, 0, 4'h0};
      t[8] = '{cw(compare_op, shift_none, 6'h00, 1'h0, 1'h1), 32'h5, 32'h7, 0, 4'h7, d0, 4'h8};
      t[9] = '{cw(compare_op, shift_none, 6'h00, 1'h0, 1'h1), 32'h8000_0000, 32'h1, 0, 4'h0, d0, 4'h3};
      t[10] = '{cw(compare_negative_op, shift_none, 6'h00, 1'h0, 1'h1), '1, 32'h1, 0, 4'h9, d0, 4'h6};
      t[11] = '{cw(compare_negative_op, shift_none, 6'h00, 1'h0, 1'h1), 32'h7FFF_FFFF, 1, 0, 0, d0, 4'h9};
      t[12] = '{cw(copy_op, left_shift, 6'h04, 1'h1, 1'h1), av, 32'h8800_0001, 0, 4'h3, 32'h8000_0010, 4'h9};
      t[13] = '{cw(copy_op, logical_right_shift, 6'h20, 1'h1, 1'h1), av, 32'h8000_0000, 0, 0, 0, 4'h6};
      t[14] = '{cw(copy_op, arith_right_shift, 6'h00, 1'h0, 1'h1), av, 32'h8000_00F0, 32'h104, 4'h2,
                32'hF800_000F, 4'h8};
      t[15] = '{cw(copy_op, rotate_right, 6'h08, 1'h1, 1'h1), av, 32'h1234_5678, 0, 4'h2, 32'h7812_3456, 0};
      t[16] = '{cw(copy_op, rotate_with_extend, 6'h00, 1'h0, 1'h1), av, 32'h3, 0, 4'h2, 32'h8000_0001, 4'hA};
      t[17] = '{cw(copy_op, left_shift, 6'h00, 1'h0, 1'h1), av, 0, 32'h100, 4'h2, 0, 4'h6};
      t[18] = '{cw(copy_inverted, shift_none, 6'h00, 1'h0, 1'h1), av, 32'hF, 0, 4'h0, 32'hFFFF_FFF0, 4'h8};
      t[19] = '{cw(load_wide_imm, shift_none, 6'h00, 1'h0, 1'h1), av, 32'h1_FFFF, 0, 4'h5, 32'hFFFF, 4'h5};
      t[20] = '{cw(load_top_half, shift_none, 6'h00, 1'h0, 1'h1), av, 32'hABCD, 0, 4'h5, 32'hABCD_5A5A, 4'h5};
      t[21] = '{cw(copy_op, shift_none, 6'h00, 1'h0, 1'h1) & ~32'h2_0000, av, 1, 0, 4'h5, d0, 4'h5};
      resetn_i = 1'h0;
      repeat (12) @(posedge clock_i);
      resetn_i <= 1'h1;
      for (i = 0; i < 7; i++) begin
         host.rd(8'(4 * i), d, r);
         chk(d, REG_RST);
      end
      for (i = 0; i < 22; i++) begin
         host.wr(OFS_FLAGS, 32'(t[i].fi), r);
         host.wr(OFS_DEST, d0, r);
         host.wr(OFS_SRC_A, t[i].a, r);
         host.wr(OFS_SRC_B, t[i].b, r);
         host.wr(OFS_SHIFT, t[i].s, r);
         host.wr(OFS_CTRL, t[i].c, r);
         repeat (2) @(posedge clock_i);
         host.rd(OFS_DEST, d, r);
         chk(d, t[i].d);
         host.rd(OFS_FLAGS, d, r);
         chk(d, 32'(t[i].fe));
      end
      host.wr(OFS_CTRL, cw(copy_op, left_shift, 6'h20, 1'h1, 1'h1), r);
      repeat (2) @(posedge clock_i);
      host.rd(OFS_STATUS, d, r);
      chk(d, 32'h4);
      host.rd(OFS_DEST, d, r);
      chk(d, d0);
      host.rd(OFS_SRC_B, d, r);
      chk(d, 32'h1);
      host.rd(OFS_CTRL, d, r);
      chk(d, cw(copy_op, left_shift, 6'h20, 1'h1, 1'h1) & CTRL_MASK);
      host.rd(8'h1C, d, r);
      chk({d[29:0], r}, {30'h0, RESP_SLVERR});
      host.wr(OFS_STATUS, 32'h7, r);
      chk(32'(r), 32'(RESP_SLVERR));
      chk(32'(n_br), 0);
      // Program counter only as plain unshifted copy
      host.wr(OFS_SRC_B, 32'h1235, r);
      host.wr(OFS_CTRL, cw(copy_op, shift_none, 6'h00, 1'h0, 1'h0) | 32'h4_0000, r);
      repeat (3) @(posedge clock_i);
      chk(32'(n_br), 1);
      chk(br_addr, 32'h1234);
      // Reset in mid-run clears state
      resetn_i <= 1'h0;
      repeat (2) @(posedge clock_i);
      resetn_i <= 1'h1;
      chk(branch_addr, REG_RST);
      host.rd(OFS_DEST, d, r);
      chk(d, REG_RST);
      host.rd(OFS_FLAGS, d, r);
      chk(d, REG_RST);
      end_of_test();
   end
endmodule
`default_nettype wire

/* File: verilog/alu_pkg.sv */
`default_nettype none
package alu_pkg;
   // Register byte offsets
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_SRC_A  = 8'h04;
   localparam logic [7:0] OFS_SRC_B  = 8'h08;
   localparam logic [7:0] OFS_SHIFT  = 8'h0C;
   localparam logic [7:0] OFS_DEST   = 8'h10;
   localparam logic [7:0] OFS_FLAGS  = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   // Control fields
   localparam int unsigned CTRL_OP_LO    = 0;
   localparam int unsigned OP_W          = 4;
   localparam int unsigned CTRL_SK_LO    = 4;
   localparam int unsigned SK_W          = 3;
   localparam int unsigned CTRL_IMM_BIT  = 7;
   localparam int unsigned CTRL_AMT_LO   = 8;
   localparam int unsigned AMT_W         = 6;
   localparam int unsigned CTRL_SET_BIT  = 16;
   localparam int unsigned CTRL_COND_BIT = 17;
   localparam int unsigned CTRL_PC_BIT   = 18;
   localparam int unsigned CTRL_GO_BIT   = 31;
   localparam logic [31:0] CTRL_MASK     = 32'h0007_3FFF;
   // Flag and status fields
   localparam int unsigned FLAG_N   = 3;
   localparam int unsigned FLAG_Z   = 2;
   localparam int unsigned FLAG_C   = 1;
   localparam int unsigned FLAG_V   = 0;
   localparam int unsigned STAT_WR  = 0;
   localparam int unsigned STAT_BR  = 1;
   localparam int unsigned STAT_ERR = 2;
   // Limits and reset values
   localparam logic [5:0] CLZ_ALL_ZERO = 6'h20;
   localparam logic [5:0] IMM_MAX_LONG = 6'h20;
   localparam logic [5:0] IMM_MAX_SHORT = 6'h1F;
   localparam logic [31:0] REG_RST     = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
   // Operations and shift kinds
   typedef enum logic [3:0] {
      op_conj, bitwise_xor_op, bitwise_disjunction, bit_clear_op,
      disjunction_inverted, leading_zero_count, compare_op,
      compare_negative_op, copy_op, copy_inverted, load_wide_imm,
      load_top_half
   } op_e;
   typedef enum logic [2:0] {
      shift_none, left_shift, logical_right_shift, arith_right_shift,
      rotate_right, rotate_with_extend
   } shift_e;
endpackage
`default_nettype wire

/* File: verilog/logic_shift_move_alu.sv */
// What this block does
// - And, xor, or combine first source and second operand bitwise into destination.
// - Bit clear ands first source with inverted second operand.
// - Or-not ors first source with inverted second operand.
// - Logic and copy ops set N, Z, carry from shifter; V untouched.
// - Register shift amount uses only low eight bits, zero to 255.
// - Immediate amounts: right shifts 1-32, left 0-31, rotate 1-31.
// - Rotate with extend shifts right by exactly one bit.
// - Shifts write destination only; shifted source stays unchanged.
// - Shift flags: N, Z from result, carry last out, zero amount keeps.
// - Leading zero count: 32 for zero source, zero when top bit set.
// - Leading zero count changes no flag.
// - Compare subtracts, sets all four flags, discards difference.
// - Compare negative adds, sets all four flags, writes no destination.
// - Copy moves second operand; wide form takes zero-extended 0-65535.
// - Wide immediate copy takes second source bits 15-0 unshifted whatever the immediate bit says.
// - Copy inverted writes bitwise inverse of second operand.
// - Copy with register shift equals the matching standalone shift.
// - Copy to program counter clears bit 0 and branches there.
// - Top-half load writes bits 31-16, keeps 15-0 and flags.
`timescale 1ns/100ps
`default_nettype none
module logic_shift_move_alu import alu_pkg::*; (
   input  wire logic              clock_i,
   input  wire logic              resetn_i,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic              s_axi_awvalid_i,
   output var  logic              s_axi_awready_o,
   input  wire logic [31:0]       s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   input  wire logic              s_axi_wvalid_i,
   output var  logic              s_axi_wready_o,
   output var  logic [1:0]        s_axi_bresp_o,
   output var  logic              s_axi_bvalid_o,
   input  wire logic              s_axi_bready_i,
   input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic              s_axi_arvalid_i,
   output var  logic              s_axi_arready_o,
   output var  logic [31:0]       s_axi_rdata_o,
   output var  logic [1:0]        s_axi_rresp_o,
   output var  logic              s_axi_rvalid_o,
   input  wire logic              s_axi_rready_i,
   output var  logic              branch_o,
   output var  logic [31:0]       branch_addr_o
);

////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [ADDR_W-1:0] aw_addr_q;
   logic              aw_held_q;
   logic [31:0]       w_data_q;
   logic [3:0]        w_strb_q;
   logic              w_held_q;
   logic              wr_fire;
   logic              wr_hit;
   logic [31:0]       ctrl_q;
   logic [31:0]       src_a_q;
   logic [31:0]       src_b_q;
   logic [31:0]       shift_q;
   logic [31:0]       dest_q;
   logic [3:0]        flags_q;
   logic [2:0]        status_q;
   logic              exec_q;
   logic [31:0]       rd_val;
   logic              rd_hit;
   op_e               op;
   shift_e            sk;
   logic              imm;
   logic [5:0]        amt6;
   logic [7:0]        amt;
   logic              err;
   logic              ok;
   logic [31:0]       sh_res;
   logic              sh_c;
   logic [63:0]       t64;
   logic [5:0]        clz_cnt;
   logic [32:0]       sum;
   logic [31:0]       res;
   logic              wr_dest;
   logic              wr_flags;
   logic              new_c;
   logic              new_v;
   logic              to_pc;
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (data & m) | (old & ~m);
   endfunction

////////////////////////////////////////////////////////////////////////
   // Write channel
   assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid_o;
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         aw_held_q       <= 1'b0;
         aw_addr_q       <= '0;
         s_axi_awready_o <= 1'b0;
      end else if (s_axi_awvalid_i && s_axi_awready_o) begin
         aw_held_q       <= 1'b1;
         aw_addr_q       <= s_axi_awaddr_i;
         s_axi_awready_o <= 1'b0;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
         aw_held_q       <= 1'b0;
         s_axi_awready_o <= 1'b1;
      end else if (!aw_held_q) begin
         s_axi_awready_o <= 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         w_held_q       <= 1'b0;
         w_data_q       <= '0;
         w_strb_q       <= '0;
         s_axi_wready_o <= 1'b0;
      end else if (s_axi_wvalid_i && s_axi_wready_o) begin
         w_held_q       <= 1'b1;
         w_data_q       <= s_axi_wdata_i;
         w_strb_q       <= s_axi_wstrb_i;
         s_axi_wready_o <= 1'b0;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
         w_held_q       <= 1'b0;
         s_axi_wready_o <= 1'b1;
      end else if (!w_held_q) begin
         s_axi_wready_o <= 1'b1;
      end
   end

   assign wr_hit = (aw_addr_q == OFS_CTRL) || (aw_addr_q == OFS_SRC_A)
                || (aw_addr_q == OFS_SRC_B) || (aw_addr_q == OFS_SHIFT)
                || (aw_addr_q == OFS_DEST) || (aw_addr_q == OFS_FLAGS);

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

////////////////////////////////////////////////////////////////////////
   // Software registers
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_q  <= REG_RST;
         src_a_q <= REG_RST;
         src_b_q <= REG_RST;
         shift_q <= REG_RST;
         exec_q  <= 1'b0;
      end else begin
         exec_q <= wr_fire && (aw_addr_q == OFS_CTRL) && w_strb_q[3]
                && w_data_q[CTRL_GO_BIT];
         if (wr_fire) begin
            case (aw_addr_q)
               OFS_CTRL:  ctrl_q  <= merge(ctrl_q, w_data_q, w_strb_q) & CTRL_MASK;
               OFS_SRC_A: src_a_q <= merge(src_a_q, w_data_q, w_strb_q);
               OFS_SRC_B: src_b_q <= merge(src_b_q, w_data_q, w_strb_q);
               OFS_SHIFT: shift_q <= merge(shift_q, w_data_q, w_strb_q);
               default: ;
            endcase
         end
      end
   end

////////////////////////////////////////////////////////////////////////
   // Operand shifter
   assign op   = op_e'(ctrl_q[CTRL_OP_LO +: OP_W]);
   assign sk   = shift_e'(ctrl_q[CTRL_SK_LO +: SK_W]);
   assign imm  = ctrl_q[CTRL_IMM_BIT];
   assign amt6 = ctrl_q[CTRL_AMT_LO +: AMT_W];
   assign amt  = imm ? {2'h0, amt6} : shift_q[7:0];

   always_comb begin
      case (sk)
         left_shift:          err = imm && (amt6 > IMM_MAX_SHORT);
         logical_right_shift,
         arith_right_shift:   err = imm && ((amt6 == 6'h0) || (amt6 > IMM_MAX_LONG));
         rotate_right:        err = imm && ((amt6 == 6'h0) || (amt6 > IMM_MAX_SHORT));
         default:             err = 1'b0;
      endcase
   end
   always_comb begin
      sh_res = src_b_q;
      sh_c   = flags_q[FLAG_C];
      t64    = {src_b_q, src_b_q} >> amt[4:0];
      if (amt != 8'h0) begin
         case (sk)
            left_shift:          {sh_c, sh_res} = {1'b0, src_b_q} << amt;
            logical_right_shift: {sh_res, sh_c} = {src_b_q, 1'b0} >> amt;
            arith_right_shift:   {sh_res, sh_c} = $unsigned($signed({src_b_q, 1'b0}) >>> amt);
            rotate_right:        {sh_res, sh_c} = {t64[31:0], t64[31]};
            default: ;
         endcase
      end
      if (sk == rotate_with_extend) begin
         sh_res = {flags_q[FLAG_C], src_b_q[31:1]};
         sh_c   = src_b_q[0];
      end
   end

////////////////////////////////////////////////////////////////////////
   // Operation unit
   always_comb begin
      clz_cnt = CLZ_ALL_ZERO;
      for (int i = 0; i < 32; i++) begin
         if (src_b_q[i]) begin
            clz_cnt = 6'(31 - i);
         end
      end
   end

   always_comb begin
      res      = sh_res;
      sum      = '0;
      wr_dest  = 1'b1;
      wr_flags = ctrl_q[CTRL_SET_BIT];
      new_c    = sh_c;
      new_v    = flags_q[FLAG_V];
      to_pc    = 1'b0;
      case (op)
         op_conj:              res = src_a_q & sh_res;
         bitwise_xor_op:       res = src_a_q ^ sh_res;
         bitwise_disjunction:  res = src_a_q | sh_res;
         bit_clear_op:         res = src_a_q & ~sh_res;
         disjunction_inverted: res = src_a_q | ~sh_res;
         leading_zero_count: begin
            res      = {26'h0, clz_cnt};
            wr_flags = 1'b0;
         end
         compare_op: begin
            sum      = {1'b0, src_a_q} + {1'b0, ~sh_res} + 33'h1;
            res      = sum[31:0];
            wr_dest  = 1'b0;
            wr_flags = 1'b1;
            new_c    = sum[32];
            new_v    = (src_a_q[31] != sh_res[31]) && (sum[31] != src_a_q[31]);
         end
         compare_negative_op: begin
            sum      = {1'b0, src_a_q} + {1'b0, sh_res};
            res      = sum[31:0];
            wr_dest  = 1'b0;
            wr_flags = 1'b1;
            new_c    = sum[32];
            new_v    = (src_a_q[31] == sh_res[31]) && (sum[31] != src_a_q[31]);
         end
         copy_op: begin
            to_pc = ctrl_q[CTRL_PC_BIT];
            res   = to_pc ? {sh_res[31:1], 1'b0} : sh_res;
         end
         copy_inverted: res = ~sh_res;
         load_wide_imm: begin
            res      = {16'h0, src_b_q[15:0]};
            wr_flags = 1'b0;
         end
         load_top_half: begin
            res      = {src_b_q[15:0], dest_q[15:0]};
            wr_flags = 1'b0;
         end
         default: begin
            wr_dest  = 1'b0;
            wr_flags = 1'b0;
         end
      endcase
   end
   assign ok = exec_q && ctrl_q[CTRL_COND_BIT] && !err;
////////////////////////////////////////////////////////////////////////
   // Destination, flags and status
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dest_q <= REG_RST;
      end else if (ok && wr_dest) begin
         dest_q <= res;
      end else if (wr_fire && (aw_addr_q == OFS_DEST)) begin
         dest_q <= merge(dest_q, w_data_q, w_strb_q);
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         flags_q <= '0;
      end else if (ok && wr_flags) begin
         flags_q[FLAG_N] <= res[31];
         flags_q[FLAG_Z] <= (res == 32'h0);
         flags_q[FLAG_C] <= new_c;
         flags_q[FLAG_V] <= new_v;
      end else if (wr_fire && (aw_addr_q == OFS_FLAGS) && w_strb_q[0]) begin
         flags_q <= w_data_q[3:0];
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         status_q      <= '0;
         branch_o      <= 1'b0;
         branch_addr_o <= REG_RST;
      end else begin
         branch_o <= ok && to_pc;
         if (exec_q) begin
            status_q[STAT_WR]  <= ok && wr_dest;
            status_q[STAT_BR]  <= ok && to_pc;
            status_q[STAT_ERR] <= err;
         end
         if (ok && to_pc) begin
            branch_addr_o <= res;
         end
      end
   end

////////////////////////////////////////////////////////////////////////
   // Read channel
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 32'h0;
      case (s_axi_araddr_i)
         OFS_CTRL:   rd_val = ctrl_q;
         OFS_SRC_A:  rd_val = src_a_q;
         OFS_SRC_B:  rd_val = src_b_q;
         OFS_SHIFT:  rd_val = shift_q;
         OFS_DEST:   rd_val = dest_q;
         OFS_FLAGS:  rd_val = {28'h0, flags_q};
         OFS_STATUS: rd_val = {29'h0, status_q};
         default:    rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= '0;
         s_axi_rresp_o   <= RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b1;
         s_axi_rdata_o   <= rd_val;
         s_axi_rresp_o   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_rvalid_o  <= 1'b0;
         s_axi_arready_o <= 1'b1;
      end else if (!s_axi_rvalid_o) begin
         s_axi_arready_o <= 1'b1;
      end
   end

////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_run;
      exec_q && ctrl_q[CTRL_COND_BIT] && !err;
   endsequence
   sequence s_skip;
      exec_q && !ctrl_q[CTRL_COND_BIT];
   endsequence
   a_logic_bitwise: assert property (@(posedge clock_i) disable iff (!resetn_i)
      s_run ##0 (op == bit_clear_op) |=> (dest_q == ($past(src_a_q) & ~$past(sh_res))))
      else $error("bit clear result wrong");
   a_overflow_kept: assert property (@(posedge clock_i) disable iff (!resetn_i)
      s_run ##0 (op inside {[op_conj:disjunction_inverted], copy_op, copy_inverted}) |=>
      (flags_q[FLAG_V] == $past(flags_q[FLAG_V])))
      else $error("overflow changed by logic op");
   a_zero_shift_c: assert property (@(posedge clock_i) disable iff (!resetn_i)
      s_run ##0 ((op == copy_op) && (amt == 8'h0) && (sk != rotate_with_extend)) |=>
      $stable(flags_q[FLAG_C]))
      else $error("carry changed on zero shift");
   a_source_kept: assert property (@(posedge clock_i) disable iff (!resetn_i)
      exec_q |=> $stable(src_b_q) ##1 $stable(src_b_q))
      else $error("shifted source altered");
   a_clz_zero: assert property (@(posedge clock_i) disable iff (!resetn_i)
      s_run ##0 ((op == leading_zero_count) && (src_b_q == 32'h0)) |=> (dest_q == 32'h20))
      else $error("leading zero count of zero not 32");
   a_clz_flags: assert property (@(posedge clock_i) disable iff (!resetn_i)
      exec_q && (op == leading_zero_count) |=> $stable(flags_q))
      else $error("leading zero count changed flags");
   a_compare_nowrite: assert property (@(posedge clock_i) disable iff (!resetn_i)
      exec_q && (op inside {compare_op, compare_negative_op}) |=> $stable(dest_q))
      else $error("compare wrote destination");
   a_cond_false: assert property (@(posedge clock_i) disable iff (!resetn_i)
      s_skip |=> $stable(dest_q) && $stable(flags_q))
      else $error("failed condition changed state");
   a_pc_branch: assert property (@(posedge clock_i) disable iff (!resetn_i)
      s_run ##0 ((op == copy_op) && ctrl_q[CTRL_PC_BIT]) |=>
      branch_o && !branch_addr_o[0] ##1 !branch_o)
      else $error("program counter copy branch wrong");
   a_top_half: assert property (@(posedge clock_i) disable iff (!resetn_i)
      s_run ##0 (op == load_top_half) |=> $stable(dest_q[15:0]) && $stable(flags_q))
      else $error("top half load disturbed low half");
endmodule
`default_nettype wire
